// [dv/can_transceiver_mode_control_test.sv]
// Self-checking bench for the transceiver mode controller.
// Assumes registers reached over AHB-Lite at byte address four times the index.
`timescale 1ns/1ps
`include "ctmc_defs.vh"

module can_transceiver_mode_control_test;
  reg         hclk, hresetn, hsel, hwrite, tx_timeout_in, bus_dominant;
  reg         mcu_supply_low, battery_uv, stuck_low, send;
  reg  [31:0] haddr, hwdata, rd;
  reg  [1:0]  htrans;
  reg  [2:0]  hsize, chip_mode_code, es;
  wire        hreadyout, hresp, txd, tx_enable, rx_enable, bias_mid, bias_gnd, rxd_force_low;
  wire [31:0] hrdata;
  wire [2:0]  xcvr_state;
  integer     num_errors, n_compared, i;

  // Short timing parameters: silence 100 cycles, wake phases 10 cycles.
  ctmc_top #(.SILENCE_NS(400), .WAKE_TO_NS(4000), .WAKE_DOM_NS(40), .WAKE_REC_NS(40)) dut_u (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .chip_mode_code(chip_mode_code),
    .tx_timeout_in(tx_timeout_in), .txd(txd), .bus_dominant(bus_dominant),
    .mcu_supply_low(mcu_supply_low), .battery_uv(battery_uv), .xcvr_state(xcvr_state),
    .tx_enable(tx_enable), .rx_enable(rx_enable), .bias_mid(bias_mid), .bias_gnd(bias_gnd),
    .rxd_force_low(rxd_force_low));

  ctmc_can_host host_u (.hclk(hclk), .stuck_low(stuck_low), .send(send), .txd(txd));

  // One single-word transfer; rd holds the read data at the data phase end.
  task xfer(input w, input [7:0] idx, input [31:0] d);
    begin
      hsel <= 1'b1;
      htrans <= 2'b10;
      hwrite <= w;
      haddr <= {22'h000000, idx, 2'b00};
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      rd = hrdata;
    end
  endtask

  // Compares a register word.
  task chk_word(input [31:0] got, input [31:0] exp);
    begin
      n_compared = n_compared + 1;
      if (got !== exp)
      begin
        num_errors = num_errors + 1;
        $display("unexpected %0t: word %h want %h", $time, got, exp);
      end
    end
  endtask

  // Lets the synchronisers and the state register settle, then compares.
  task chk_state(input [2:0] exp);
    begin
      repeat (6) @(posedge hclk);
      n_compared = n_compared + 1;
      if (xcvr_state !== exp)
      begin
        num_errors = num_errors + 1;
        $display("unexpected %0t: state %h want %h", $time, xcvr_state, exp);
      end
    end
  endtask

  // Dominant, recessive, dominant phases of 14 cycles each.
  task wake_pat;
    begin
      for (i = 0; i < 3; i = i + 1)
      begin
        bus_dominant <= ~i[0];
        repeat (14) @(posedge hclk);
      end
      bus_dominant <= 1'b0;
    end
  endtask

  // One short dominant pulse restarts the bus silence count.
  task bus_blip;
    begin
      bus_dominant <= 1'b1;
      @(posedge hclk);
      bus_dominant <= 1'b0;
    end
  endtask

  // Prints the verdict and stops.
  task end_of_test;
    begin
      if (num_errors == 0 && n_compared > 0)
        $display("TEST PASSED");
      else
        $display("TEST FAILED");
      $finish;
    end
  endtask

  initial
  begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end

  // Cuts a hang short after 20000 cycles.
  initial
  begin
    #80000;
    num_errors = num_errors + 1;
    end_of_test;
  end

  // ----------------------------------------------------------------------
  // Main sequence.
  // ----------------------------------------------------------------------
  initial
  begin
    {hresetn, hsel, hwrite, tx_timeout_in, bus_dominant} = 5'h00;
    {mcu_supply_low, battery_uv, stuck_low, send} = 4'h0;
    {haddr, hwdata, htrans, hsize} = {64'h0, 2'b00, 3'b010};
    chip_mode_code = `CTMC_CHIP_NORMAL;
    num_errors = 0;
    n_compared = 0;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    xfer(0, `CTMC_IDX_MODE_CTRL, 0);
    chk_word(rd, `CTMC_MODE_CTRL_RST);
    xfer(0, `CTMC_IDX_EVENT_EN, 0);
    chk_word(rd, `CTMC_EVENT_EN_RST);
    xfer(0, 8'h30, 0);
    chk_word(rd, 32'h0);
    xfer(1, `CTMC_IDX_MODE_CTRL, 32'hfc);
    xfer(0, `CTMC_IDX_MODE_CTRL, 0);
    chk_word(rd, 32'hfc);
    chk_state(`CTMC_ST_OFFLINE);
    wake_pat;
    chk_state(`CTMC_ST_OFFBIAS);
    xfer(0, `CTMC_IDX_EVENT, 0);
    chk_word(rd, 32'h0);
    repeat (130) @(posedge hclk);
    chk_state(`CTMC_ST_OFFLINE);
    xfer(0, `CTMC_IDX_STATE_FLAGS, 0);
    chk_word(rd & 32'h20, 32'h20);
    xfer(1, `CTMC_IDX_EVENT_EN, 1);
    wake_pat;
    chk_state(`CTMC_ST_OFFBIAS);
    xfer(0, `CTMC_IDX_EVENT, 0);
    chk_word(rd & 32'h1, 32'h1);
    chk_word({31'h0, rxd_force_low}, 32'h1);
    xfer(1, `CTMC_IDX_EVENT, 1);
    xfer(0, `CTMC_IDX_EVENT, 0);
    chk_word(rd & 32'h1, 32'h0);
    for (i = 1; i < 5; i = i + 1)
    begin
      es = (i < 3) ? `CTMC_ST_ACTIVE : (i == 3) ? `CTMC_ST_LISTEN : `CTMC_ST_OFFBIAS;
      bus_blip;
      xfer(1, `CTMC_IDX_MODE_CTRL, i % 4);
      chk_state(es);
      xfer(0, `CTMC_IDX_STATE_FLAGS, 0);
      chk_word(rd & 32'h81, (i < 3) ? 32'h80 : 32'h0);
    end
    xfer(1, `CTMC_IDX_MODE_CTRL, 1);
    chk_state(`CTMC_ST_ACTIVE);
    mcu_supply_low <= 1'b1;
    chk_state(`CTMC_ST_OFFBIAS);
    xfer(0, `CTMC_IDX_STATE_FLAGS, 0);
    chk_word(rd & 32'h2, 32'h2);
    xfer(1, `CTMC_IDX_MODE_CTRL, 2);
    xfer(0, `CTMC_IDX_STATE_FLAGS, 0);
    chk_word(rd & 32'h2, 32'h0);
    mcu_supply_low <= 1'b0;
    xfer(1, `CTMC_IDX_MODE_CTRL, 1);
    chk_state(`CTMC_ST_ACTIVE);
    xfer(0, `CTMC_IDX_STATE_FLAGS, 0);
    chk_word(rd & 32'h2, 32'h0);
    tx_timeout_in <= 1'b1;
    xfer(0, `CTMC_IDX_STATE_FLAGS, 0);
    chk_word(rd & 32'h81, 32'h01);
    tx_timeout_in <= 1'b0;
    xfer(0, `CTMC_IDX_STATE_FLAGS, 0);
    chk_word(rd & 32'h81, 32'h80);
    chip_mode_code <= `CTMC_CHIP_FNORMAL;
    send <= 1'b1;
    chk_state(`CTMC_ST_ACTIVE);
    mcu_supply_low <= 1'b1;
    chk_state(`CTMC_ST_LISTEN);
    mcu_supply_low <= 1'b0;
    send <= 1'b0;
    chip_mode_code <= `CTMC_CHIP_NORMAL;
    bus_blip;
    xfer(1, `CTMC_IDX_MODE_CTRL, 0);
    chk_state(`CTMC_ST_OFFBIAS);
    stuck_low <= 1'b1;
    repeat (4) @(posedge hclk);
    xfer(1, `CTMC_IDX_MODE_CTRL, 1);
    chk_state(`CTMC_ST_LISTEN);
    stuck_low <= 1'b0;
    chk_state(`CTMC_ST_ACTIVE);
    chip_mode_code <= `CTMC_CHIP_STANDBY;
    chk_state(`CTMC_ST_OFFBIAS);
    chip_mode_code <= `CTMC_CHIP_OFF;
    chk_state(`CTMC_ST_OFF);
    chip_mode_code <= `CTMC_CHIP_RESET;
    chk_state(`CTMC_ST_OFFLINE);
    battery_uv <= 1'b1;
    chk_state(`CTMC_ST_OFF);
    battery_uv <= 1'b0;
    chk_state(`CTMC_ST_OFFLINE);
    end_of_test;
  end
endmodule

// [dv/ctmc_can_host.sv]
// Behavioural CAN protocol controller driving the transmit pin.
// Assumes the bench commands a stuck-low fault or a traffic burst.
`timescale 1ns/1ps

module ctmc_can_host (
  input wire hclk,
  input wire stuck_low,
  input wire send,
  output reg txd
);
  reg [3:0] bit_q; // Bit pacing counter.

  initial
  begin
    txd = 1'b1;
    bit_q = 4'h0;
  end

  // Idle is recessive; a burst toggles every four cycles.
  always @(posedge hclk)
  begin
    bit_q <= bit_q + 4'h1;
    if (stuck_low)
      txd <= 1'b0;
    else if (send)
      txd <= bit_q[2];
    else
      txd <= 1'b1;
  end
endmodule

// [dv/ctmc_props_properties.sv]
// Concurrent checks on the transceiver mode controller's top ports.
// Assumes a single hclk domain with hresetn as asynchronous low reset.
`timescale 1ns/1ps
`include "ctmc_defs.vh"

module ctmc_props (
  input wire       hclk,
  input wire       hresetn,
  input wire       hreadyout,
  input wire       hresp,
  input wire [2:0] chip_mode_code,
  input wire       tx_timeout_in,
  input wire       txd,
  input wire [2:0] xcvr_state,
  input wire       tx_enable,
  input wire       rx_enable,
  input wire       bias_mid,
  input wire       bias_gnd,
  input wire       rxd_force_low
);
  // ----------------------------------------------------------------------
  // Clocking and reset shared by every property.
  // ----------------------------------------------------------------------
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  // Mid bias is on exactly in the biased states.
  bias_mid_state_a : assert property (bias_mid == (xcvr_state inside
    {`CTMC_ST_ACTIVE, `CTMC_ST_LISTEN, `CTMC_ST_OFFBIAS})) else $error("bias mid wrong");
  // Ground bias is on in the Offline state only.
  bias_gnd_state_a : assert property (bias_gnd == (xcvr_state == `CTMC_ST_OFFLINE))
    else $error("bias gnd wrong");
  // The transmitter runs only in Active without a stuck timeout.
  tx_enable_a : assert property (tx_enable ==
    (xcvr_state == `CTMC_ST_ACTIVE && !tx_timeout_in)) else $error("tx enable wrong");
  // The receiver is off only while the transceiver is off.
  rx_enable_a : assert property (rx_enable == (xcvr_state != `CTMC_ST_OFF))
    else $error("rx enable wrong");
  // Chip Off or Overtemp switches the transceiver off one edge later.
  off_float_a : assert property ((chip_mode_code == `CTMC_CHIP_OFF ||
    chip_mode_code == `CTMC_CHIP_OVERTEMP) |=> xcvr_state == `CTMC_ST_OFF)
    else $error("not off in off mode");
  // Standby never leaves the transceiver transmitting or listening.
  standby_offline_a : assert property (chip_mode_code == `CTMC_CHIP_STANDBY |=>
    !(xcvr_state inside {`CTMC_ST_ACTIVE, `CTMC_ST_LISTEN})) else $error("standby online");
  // Settled Forced Normal means Active or Listen-only unless switched off.
  forced_normal_a : assert property ((chip_mode_code == `CTMC_CHIP_FNORMAL)[*3]
    ##0 rx_enable |=> xcvr_state inside {`CTMC_ST_OFF, `CTMC_ST_ACTIVE, `CTMC_ST_LISTEN})
    else $error("forced normal state wrong");
  // A long low transmit pin blocks entry into Active.
  txd_low_block_a : assert property ((!txd)[*5] ##1 xcvr_state == `CTMC_ST_ACTIVE
    |-> $past(xcvr_state) == `CTMC_ST_ACTIVE) else $error("active with txd low");
  // The wake indication on the receive pin only shows while offline.
  rxd_low_state_a : assert property (rxd_force_low |-> xcvr_state inside
    {`CTMC_ST_OFFLINE, `CTMC_ST_OFFBIAS}) else $error("rxd low while online");
  // The register slave never stalls and always answers OKAY.
  bus_okay_a : assert property (hreadyout && !hresp) else $error("bus answer wrong");

  // Main scenarios reached.
  cover property (xcvr_state == `CTMC_ST_ACTIVE);
  cover property (xcvr_state == `CTMC_ST_LISTEN);
  cover property ($rose(rxd_force_low));
endmodule

bind ctmc_top ctmc_props chk_u (.hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout),
  .hresp(hresp), .chip_mode_code(chip_mode_code), .tx_timeout_in(tx_timeout_in),
  .txd(txd), .xcvr_state(xcvr_state), .tx_enable(tx_enable), .rx_enable(rx_enable),
  .bias_mid(bias_mid), .bias_gnd(bias_gnd), .rxd_force_low(rxd_force_low));

// [rtl/ctmc_defs.vh]
// Constants of the CAN transceiver mode controller: register indices,
// field positions, reset values, state and chip mode codes, timing.
// Assumes inclusion by bare name from the files under rtl/.
`ifndef CTMC_DEFS_VH
`define CTMC_DEFS_VH

// ----------------------------------------------------------------------
// Register indices; the byte address is four times the index.
// ----------------------------------------------------------------------
`define CTMC_IDX_MODE_CTRL   8'h20
`define CTMC_IDX_STATE_FLAGS 8'h22
`define CTMC_IDX_EVENT       8'h23
`define CTMC_IDX_EVENT_EN    8'h24

// ----------------------------------------------------------------------
// Field positions and reset values.
// ----------------------------------------------------------------------
`define CTMC_MODE_CTRL_RST   8'h00
`define CTMC_EVENT_EN_RST    8'h00
`define CTMC_BIT_TX_READY    7
`define CTMC_BIT_BUS_SILENT  5
`define CTMC_BIT_SUPPLY_LOW  1
`define CTMC_BIT_TX_TIMEOUT  0
`define CTMC_BIT_WAKE_EVENT  0
`define CTMC_BIT_WAKE_EN     0

// ----------------------------------------------------------------------
// Mode select field codes.
// ----------------------------------------------------------------------
`define CTMC_SEL_OFFLINE     2'b00
`define CTMC_SEL_ACT_UV      2'b01
`define CTMC_SEL_ACT_NOUV    2'b10
`define CTMC_SEL_LISTEN      2'b11

// ----------------------------------------------------------------------
// Chip operating mode codes.
// ----------------------------------------------------------------------
`define CTMC_CHIP_NORMAL     3'b111
`define CTMC_CHIP_FNORMAL    3'b110
`define CTMC_CHIP_STANDBY    3'b100
`define CTMC_CHIP_RESET      3'b011
`define CTMC_CHIP_OVERTEMP   3'b001
`define CTMC_CHIP_OFF        3'b000

// ----------------------------------------------------------------------
// Transceiver state codes.
// ----------------------------------------------------------------------
`define CTMC_ST_OFF          3'h0
`define CTMC_ST_OFFLINE      3'h1
`define CTMC_ST_OFFBIAS      3'h2
`define CTMC_ST_LISTEN       3'h3
`define CTMC_ST_ACTIVE       3'h4

// ----------------------------------------------------------------------
// Timing: clock period and default times, all in nanoseconds.
// ----------------------------------------------------------------------
`define CTMC_CLK_NS          4
`define CTMC_SILENCE_NS      1000000
`define CTMC_WAKE_TO_NS      1000000
`define CTMC_WAKE_DOM_NS     5000
`define CTMC_WAKE_REC_NS     5000

`endif

// [rtl/ctmc_top.v]
// CAN transceiver mode controller with AHB-Lite register access.
// Assumes one 250 MHz clock; pins txd, bus level and supply monitors
// arrive asynchronously, chip mode and transmit timeout come on hclk.
//
// Local design decision: register access over AHB-Lite.
`timescale 1ns/1ps
`include "ctmc_defs.vh"

module ctmc_top #(
  parameter integer SILENCE_NS  = `CTMC_SILENCE_NS,
  parameter integer WAKE_TO_NS  = `CTMC_WAKE_TO_NS,
  parameter integer WAKE_DOM_NS = `CTMC_WAKE_DOM_NS,
  parameter integer WAKE_REC_NS = `CTMC_WAKE_REC_NS
) (
  input  wire        hclk,
  input  wire        hresetn,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output wire        hreadyout,
  output wire        hresp,
  output wire [31:0] hrdata,
  input  wire [2:0]  chip_mode_code,
  input  wire        tx_timeout_in,
  input  wire        txd,
  input  wire        bus_dominant,
  input  wire        mcu_supply_low,
  input  wire        battery_uv,
  output wire [2:0]  xcvr_state,
  output wire        tx_enable,
  output wire        rx_enable,
  output wire        bias_mid,
  output wire        bias_gnd,
  output wire        rxd_force_low
);

  // ----------------------------------------------------------------------
  // Timing counts derived from the clock period.
  // ----------------------------------------------------------------------
  // Least times round up, the wake window (a longest time) rounds down.
  localparam integer SIL_RAW = (SILENCE_NS + `CTMC_CLK_NS - 1) / `CTMC_CLK_NS;
  localparam integer WTO_RAW = WAKE_TO_NS / `CTMC_CLK_NS;
  localparam integer DOM_RAW = (WAKE_DOM_NS + `CTMC_CLK_NS - 1) / `CTMC_CLK_NS;
  localparam integer REC_RAW = (WAKE_REC_NS + `CTMC_CLK_NS - 1) / `CTMC_CLK_NS;
  localparam [31:0]  SIL_CYC = (SIL_RAW < 1) ? 1 : SIL_RAW;
  localparam [31:0]  WTO_CYC = (WTO_RAW < 1) ? 1 : WTO_RAW;
  localparam [31:0]  DOM_CYC = (DOM_RAW < 1) ? 1 : DOM_RAW;
  localparam [31:0]  REC_CYC = (REC_RAW < 1) ? 1 : REC_RAW;

  // Wake detector progress codes.
  localparam [1:0] WK_IDLE = 2'd0;
  localparam [1:0] WK_DOM1 = 2'd1;
  localparam [1:0] WK_REC  = 2'd2;
  localparam [1:0] WK_DOM2 = 2'd3;

  // ----------------------------------------------------------------------
  // Declarations.
  // ----------------------------------------------------------------------
  reg  [3:0]  sync1_q;       // First synchroniser stage of the four pins.
  reg  [3:0]  sync2_q;       // Second stage, the only one logic reads.
  reg         bus_prev_q;    // Previous synchronised bus level.
  reg  [7:0]  mode_ctrl_q;   // Mode control register.
  reg         wake_en_q;     // Wake detect enable bit.
  reg         wake_evt_q;    // Sticky bus wake event bit.
  reg  [2:0]  state_q;       // Transceiver state.
  reg  [2:0]  state_d;       // Next transceiver state.
  reg  [2:0]  chip_prev_q;   // Chip mode of the previous cycle.
  reg  [31:0] sil_cnt_q;     // Cycles since the last bus edge.
  reg         silent_q;      // Bus silent for longer than the timeout.
  reg  [1:0]  wk_q;          // Wake pattern progress.
  reg  [31:0] ph_cnt_q;      // Length of the current bus phase.
  reg  [31:0] win_cnt_q;     // Cycles since the first dominant phase.
  reg         ap_wr_q;       // Write pending in the data phase.
  reg  [7:0]  ap_idx_q;      // Register index of the pending write.
  reg  [31:0] hrdata_q;      // Read data of the data phase.
  reg  [7:0]  rd_val;        // Combinational read value.
  wire        txd_s;         // Synchronised transmit input.
  wire        bus_s;         // Synchronised bus level, 1 is dominant.
  wire        v1_low_s;      // Synchronised supply-low level.
  wire        bat_low_s;     // Synchronised battery undervoltage.
  wire        bus_edge;      // Bus level changed this cycle.
  wire        ap_take;       // Address phase accepted this cycle.
  wire [7:0]  ap_idx;        // Register index of the address phase.
  wire        wake_hit;      // Valid wake pattern completed.
  wire        wake_watch;    // Wake detector may track the bus.
  wire [31:0] ph_len;        // Length of the current bus phase, this cycle included.
  wire        wake_clr;      // Software clears the wake event.
  wire [1:0]  sel;           // Mode select field.
  wire [7:0]  flags;         // Transceiver state flag register.

  // ----------------------------------------------------------------------
  // Helpers.
  // ----------------------------------------------------------------------
  // Returns one when the select field asks for Active.
  function sel_active;
    input [1:0] s;
    begin
      sel_active = (s == `CTMC_SEL_ACT_UV) || (s == `CTMC_SEL_ACT_NOUV);
    end
  endfunction

  // Returns one when the chip mode turns the transceiver off.
  function chip_off;
    input [2:0] m;
    begin
      chip_off = (m == `CTMC_CHIP_OFF) || (m == `CTMC_CHIP_OVERTEMP);
    end
  endfunction

  // ----------------------------------------------------------------------
  // Pin synchronisers.
  // ----------------------------------------------------------------------
  // Two flops per pin; only the second stage is read.
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      sync1_q <= 4'h1;
      sync2_q <= 4'h1;
    end
    else
    begin
      sync1_q <= {battery_uv, mcu_supply_low, bus_dominant, txd};
      sync2_q <= sync1_q;
    end
  end

  assign txd_s     = sync2_q[0];
  assign bus_s     = sync2_q[1];
  assign v1_low_s  = sync2_q[2];
  assign bat_low_s = sync2_q[3];
  assign bus_edge  = bus_s ^ bus_prev_q;
  assign sel       = mode_ctrl_q[1:0];

  // ----------------------------------------------------------------------
  // Bus activity and silence timing.
  // ----------------------------------------------------------------------
  // Every edge restarts the count; the flag rises once it reaches the limit.
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      bus_prev_q  <= 1'b0;
      sil_cnt_q   <= 32'h0000_0000;
      silent_q    <= 1'b0;
      chip_prev_q <= `CTMC_CHIP_OFF;
    end
    else
    begin
      bus_prev_q  <= bus_s;
      chip_prev_q <= chip_mode_code;
      if (bus_edge)
      begin
        sil_cnt_q <= 32'h0000_0000;
        silent_q  <= 1'b0;
      end
      else if (sil_cnt_q < SIL_CYC)
      begin
        sil_cnt_q <= sil_cnt_q + 32'h0000_0001;
      end
      else
      begin
        silent_q <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Wake pattern detector.
  // ----------------------------------------------------------------------
  // Phases are qualified by their own length; a short pulse in between
  // only restarts the phase count and never loses the progress made.
  // Offline Bias is Offline with mid bias, so the watch goes on there; else the
  // first dominant phase, which moves Offline to Offline Bias, would end it.
  assign wake_watch = wake_en_q && (state_q == `CTMC_ST_OFFLINE ||
                      state_q == `CTMC_ST_OFFBIAS);
  // An edge starts a new phase, so the old count never qualifies it.
  assign ph_len   = bus_edge ? 32'h0000_0001 : ph_cnt_q + 32'h0000_0001;
  assign wake_hit = wake_watch && (wk_q == WK_DOM2) && bus_s && (ph_len >= DOM_CYC);

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wk_q      <= WK_IDLE;
      ph_cnt_q  <= 32'h0000_0000;
      win_cnt_q <= 32'h0000_0000;
    end
    else if (!wake_watch)
    begin
      wk_q      <= WK_IDLE;
      ph_cnt_q  <= 32'h0000_0000;
      win_cnt_q <= 32'h0000_0000;
    end
    else
    begin
      // Phase length counter restarts on each bus edge.
      ph_cnt_q <= ph_len;
      // Window counter runs once the first dominant phase is seen.
      if (wk_q != WK_IDLE)
        win_cnt_q <= win_cnt_q + 32'h0000_0001;
      case (wk_q)
        WK_IDLE:
        begin
          win_cnt_q <= 32'h0000_0000;
          if (bus_s && ph_len >= DOM_CYC)
            wk_q <= WK_DOM1;
        end
        WK_DOM1:
        begin
          if (win_cnt_q >= WTO_CYC)
            wk_q <= WK_IDLE;
          else if (!bus_s && ph_len >= REC_CYC)
            wk_q <= WK_REC;
        end
        WK_REC:
        begin
          if (win_cnt_q >= WTO_CYC)
            wk_q <= WK_IDLE;
          else if (bus_s)
            wk_q <= WK_DOM2;
        end
        WK_DOM2:
        begin
          // A dominant pulse that is too short stays in WK_DOM2, waiting for a longer one.
          if (win_cnt_q >= WTO_CYC || wake_hit)
            wk_q <= WK_IDLE;
        end
        default:
        begin
          wk_q <= WK_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Transceiver state machine.
  // ----------------------------------------------------------------------
  // Checked in order: off conditions, leaving Off, Forced Normal, reset or standby, Listen select, supply, Active select.
  always @*
  begin
    state_d = state_q;
    if (chip_off(chip_mode_code) || bat_low_s)
    begin
      state_d = `CTMC_ST_OFF;
    end
    else if (state_q == `CTMC_ST_OFF)
    begin
      state_d = `CTMC_ST_OFFLINE;
    end
    else if (chip_off(chip_prev_q))
    begin
      state_d = `CTMC_ST_OFFLINE;
    end
    else if (chip_mode_code == `CTMC_CHIP_FNORMAL)
    begin
      // Forced Normal: low supply gives Listen-only, else Active once the transmit input is recessive.
      if (v1_low_s)
        state_d = `CTMC_ST_LISTEN;
      else if (state_q == `CTMC_ST_ACTIVE || txd_s)
        state_d = `CTMC_ST_ACTIVE;
      else
        state_d = `CTMC_ST_LISTEN;
    end
    else if (chip_mode_code != `CTMC_CHIP_NORMAL ||
             sel == `CTMC_SEL_OFFLINE)
    begin
      // Reset, Standby or select 00: offline with autonomous bias.
      if (state_q == `CTMC_ST_ACTIVE || state_q == `CTMC_ST_LISTEN)
        state_d = `CTMC_ST_OFFBIAS;
      else if (state_q == `CTMC_ST_OFFLINE && (bus_edge || wake_hit))
        state_d = `CTMC_ST_OFFBIAS;
      else if (state_q == `CTMC_ST_OFFBIAS && silent_q)
        state_d = `CTMC_ST_OFFLINE;
    end
    else if (sel == `CTMC_SEL_LISTEN)
    begin
      state_d = `CTMC_ST_LISTEN;
    end
    else if (v1_low_s)
    begin
      // Select 01 or 10 with the supply below its threshold.
      if (state_q == `CTMC_ST_OFFLINE)
        state_d = `CTMC_ST_OFFBIAS;
      else if (state_q == `CTMC_ST_ACTIVE && sel == `CTMC_SEL_ACT_UV)
        state_d = `CTMC_ST_OFFBIAS;
      else if (state_q == `CTMC_ST_ACTIVE)
        state_d = `CTMC_ST_LISTEN;
      else if (state_q == `CTMC_ST_OFFBIAS && silent_q)
        state_d = `CTMC_ST_OFFLINE;
    end
    else if (sel_active(sel))
    begin
      // Entering Active needs a recessive transmit input.
      if (state_q == `CTMC_ST_ACTIVE || txd_s)
        state_d = `CTMC_ST_ACTIVE;
      else
        state_d = `CTMC_ST_LISTEN;
    end
  end

  // State register; reset leaves the transceiver off.
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      state_q <= `CTMC_ST_OFF;
    else
      state_q <= state_d;
  end

  // ----------------------------------------------------------------------
  // Transceiver outputs.
  // ----------------------------------------------------------------------
  assign xcvr_state    = state_q;
  assign tx_enable     = (state_q == `CTMC_ST_ACTIVE) && !tx_timeout_in;
  assign rx_enable     = (state_q != `CTMC_ST_OFF);
  assign bias_mid      = (state_q == `CTMC_ST_ACTIVE) ||
                         (state_q == `CTMC_ST_LISTEN) ||
                         (state_q == `CTMC_ST_OFFBIAS);
  assign bias_gnd      = (state_q == `CTMC_ST_OFFLINE);
  assign rxd_force_low = wake_evt_q && (state_q == `CTMC_ST_OFFLINE ||
                         state_q == `CTMC_ST_OFFBIAS);

  // ----------------------------------------------------------------------
  // AHB-Lite slave.
  // ----------------------------------------------------------------------
  // Zero wait states, always OKAY; unmapped reads give zero.
  assign ap_take   = hsel && hready && htrans[1];
  assign ap_idx    = haddr[9:2];
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_q;
  assign wake_clr  = ap_wr_q && (ap_idx_q == `CTMC_IDX_EVENT) &&
                     hwdata[`CTMC_BIT_WAKE_EVENT];

  // Status flags of the transceiver.
  assign flags = {tx_enable, 1'b0, silent_q, 3'b000,
                  v1_low_s && (sel == `CTMC_SEL_ACT_UV),
                  tx_timeout_in};

  // Read multiplexer over the register indices.
  always @*
  begin
    rd_val = 8'h00;
    case (ap_idx)
      `CTMC_IDX_MODE_CTRL:   rd_val = mode_ctrl_q;
      `CTMC_IDX_STATE_FLAGS: rd_val = flags;
      `CTMC_IDX_EVENT:       rd_val = {7'h00, wake_evt_q};
      `CTMC_IDX_EVENT_EN:    rd_val = {7'h00, wake_en_q};
      default:               rd_val = 8'h00;
    endcase
  end

  // Address phase capture and read data launch.
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ap_wr_q  <= 1'b0;
      ap_idx_q <= 8'h00;
      hrdata_q <= 32'h0000_0000;
    end
    else
    begin
      ap_wr_q <= ap_take && hwrite;
      if (ap_take)
        ap_idx_q <= ap_idx;
      if (ap_take && !hwrite)
        hrdata_q <= {24'h00_0000, rd_val};
    end
  end

  // Register writes land in the data phase.
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      mode_ctrl_q <= `CTMC_MODE_CTRL_RST;
      wake_en_q   <= 1'b0;
    end
    else if (ap_wr_q)
    begin
      if (ap_idx_q == `CTMC_IDX_MODE_CTRL)
        mode_ctrl_q <= hwdata[7:0];
      if (ap_idx_q == `CTMC_IDX_EVENT_EN)
        wake_en_q <= hwdata[`CTMC_BIT_WAKE_EN];
    end
  end

  // Wake event bit: write one to clear, a new wake wins over the clear.
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      wake_evt_q <= 1'b0;
    else if (wake_hit)
      wake_evt_q <= 1'b1;
    else if (wake_clr)
      wake_evt_q <= 1'b0;
  end

endmodule
